/* src/sdc_param_mem.v */
// Purpose: single-port word memory with registered read data
// Assumes: one access per cycle, write and read share the address
// Notes:   contents are not cleared by reset, like a real nvm array
`timescale 1ns/1ps
module sdc_param_mem #(
  parameter AW = 8,
  parameter DW = 32
) (
  // clock
  input  wire          clk_sys,
  // access
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // sdc_param_mem

/* src/sdc_regs.vh */
// Purpose: constants for the step/dir current control and parameter store
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// axis parameter numbers
`define SDC_AX_MODE      8'hfe
`define SDC_AX_PDD       8'hd6

// step/dir mode codes
`define SDC_MODE_NORMAL  8'h00
`define SDC_MODE_ENSEL   8'h01
`define SDC_MODE_AUTO    8'h02
`define SDC_MODE_RUN     8'h03
`define SDC_MODE_AUTO_EN 8'h04
`define SDC_MODE_RUN_EN  8'h05
`define SDC_MODE_RST     8'h00

// command opcodes
`define SDC_OP_SET       3'h0
`define SDC_OP_GET       3'h1
`define SDC_OP_ADD       3'h2
`define SDC_OP_STORE     3'h3
`define SDC_OP_RESTORE   3'h4

// banks
`define SDC_BANK_CFG     2'h0
`define SDC_BANK_UNUSED  2'h1
`define SDC_BANK_USER    2'h2
`define SDC_BANK_IRQ     2'h3

// bank 0 auto-stored range is 64 .. 127
`define SDC_AUTO_LO      8'h40
`define SDC_AUTO_HI      8'h80
`define SDC_RATE_NUM     8'h41
`define SDC_RATE_MAX     32'h00000008
`define SDC_RATE_RST     4'h0

// non-volatile slots
`define SDC_NVM_RATE     8'h01
`define SDC_NVM_USER     2'h1
`define SDC_NVM_MODE     8'h80
`define SDC_NVM_PDD      8'h81

// power-down delay, 10 ms units
`define SDC_PDD_RST      16'h00c8
`define SDC_TICK_NS      10000000
`define SDC_CLK_NS       4
`define SDC_TICK_CYC     (`SDC_TICK_NS / `SDC_CLK_NS)

`endif

/* src/sdc_top.v */
// Purpose: step/dir current mode selection and global parameter store
// Assumes: all inputs synchronous to clk_sys, enable_in active high
// Notes:   one command in flight; cmd_ready low while busy or booting
//
// What this block does
// R1: mode 0 ignores step/dir, normal motion control
// R2: mode 1 enable inputs pick hold/run current
// R3: mode 2 run on step, hold after delay
// R4: mode 3 run current always, enables ignored
// R5: mode 4 like 2, enables gate drivers
// R6: mode 5 like 3, enables gate drivers
// R7: four banks: config, unused, user, interrupt
// R8: bank 0 params 64..127 auto-stored
// R9: set on auto param persists at once
// R10: bit-rate changes apply only after power-up
// R11: access classes: get, set/add, store/restore
// R12: unused bank: writes ignored, reads zero
// R13: mode above five rejected, old kept
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_top #(
  parameter TICK_CYC = `SDC_TICK_CYC,
  parameter TICK_W   = 22
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // parameter command
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [2:0]  cmd_op,
  input  wire        cmd_axis,
  input  wire [1:0]  cmd_bank,
  input  wire [7:0]  cmd_num,
  input  wire [31:0] cmd_data,
  // parameter answer
  output reg         rsp_valid_r,
  output reg         rsp_err_r,
  output reg  [31:0] rsp_data_r,
  // step/dir connector
  input  wire        step_in,
  input  wire        enable_in,
  input  wire        motion_run_req,
  // motor driver
  output reg         run_current_r,
  output reg         driver_on_r,
  output reg         step_mode_on_r,
  output reg  [3:0]  active_rate_r
);
  localparam ST_BOOT0 = 3'h0;
  localparam ST_BOOT1 = 3'h1;
  localparam ST_BOOT2 = 3'h2;
  localparam ST_IDLE  = 3'h3;
  localparam ST_EXEC  = 3'h4;
  localparam ST_WAIT  = 3'h5;

  reg  [2:0]  state_r;
  reg  [2:0]  op_r;
  reg         axis_r;
  reg  [1:0]  bank_r;
  reg  [7:0]  num_r;
  reg  [31:0] data_r;
  reg  [7:0]  mode_r;
  reg  [15:0] pdd_r;

  reg         nvm_we;
  reg  [7:0]  nvm_addr;
  reg  [31:0] nvm_wd;
  wire [31:0] nvm_rd;
  reg         ram_we;
  reg  [6:0]  ram_addr;
  reg  [31:0] ram_wd;
  wire [31:0] ram_rd;

  // command decode on the latched fields
  wire g_auto   = !axis_r && (bank_r == `SDC_BANK_CFG) &&
                  (num_r >= `SDC_AUTO_LO) && (num_r < `SDC_AUTO_HI);
  wire g_unused = !axis_r && (bank_r == `SDC_BANK_UNUSED);
  wire g_user   = !axis_r && bank_r[1] && (num_r < 8'h40);
  wire a_mode   = axis_r && (num_r == `SDC_AX_MODE);
  wire a_pdd    = axis_r && (num_r == `SDC_AX_PDD);
  wire op_set   = (op_r == `SDC_OP_SET);
  wire op_get   = (op_r == `SDC_OP_GET);
  wire op_add   = (op_r == `SDC_OP_ADD);
  wire op_sto   = (op_r == `SDC_OP_STORE);
  wire op_rst   = (op_r == `SDC_OP_RESTORE);
  wire op_known = op_set || op_get || op_add || op_sto || op_rst;
  wire usr_irq  = (bank_r == `SDC_BANK_IRQ);

  // illegal target or access class not held by the target
  wire bad = !op_known ||
             !(g_auto || g_unused || g_user || a_mode || a_pdd) ||
             (axis_r && op_add) ||
             (g_user && usr_irq && (op_sto || op_rst));     // see R11
  // ops that finish one cycle later on registered read data
  wire need_rd = !bad && ((g_auto && (op_get || op_add)) ||
                          (g_user && !op_set) ||
                          (axis_r && op_rst));

  wire [31:0] mode_w = {24'h000000, mode_r};
  wire [31:0] pdd_w  = {16'h0000, pdd_r};

  assign cmd_ready = (state_r == ST_IDLE);

  // memory steering
  always @* begin
    nvm_we   = 1'b0;
    nvm_addr = 8'h00;
    nvm_wd   = data_r;
    ram_we   = 1'b0;
    ram_addr = {bank_r[0], num_r[5:0]};
    ram_wd   = data_r;
    case (state_r)
      ST_BOOT0: begin
        nvm_addr = `SDC_NVM_RATE;
      end
      ST_BOOT1: begin
        nvm_addr = `SDC_NVM_MODE;
      end
      ST_EXEC: begin
        if (!bad && g_auto) begin
          nvm_addr = num_r - `SDC_AUTO_LO;
          nvm_we   = op_set;                                 // see R9
        end else if (!bad && g_user) begin
          nvm_addr = {`SDC_NVM_USER, num_r[5:0]};
          ram_we   = op_set;
        end else if (!bad && axis_r) begin
          nvm_addr = a_mode ? `SDC_NVM_MODE : `SDC_NVM_PDD;
          nvm_we   = op_sto;                                 // see R11
          nvm_wd   = a_mode ? mode_w : pdd_w;
        end
      end
      ST_WAIT: begin
        if (g_auto) begin
          nvm_addr = num_r - `SDC_AUTO_LO;
          nvm_we   = op_add;                                 // see R9
          nvm_wd   = nvm_rd + data_r;
        end else if (g_user) begin
          nvm_addr = {`SDC_NVM_USER, num_r[5:0]};
          nvm_we   = op_sto;                                 // see R11
          nvm_wd   = ram_rd;
          ram_we   = op_add || op_rst;
          ram_wd   = op_add ? ram_rd + data_r : nvm_rd;
        end
      end
      default: begin
        nvm_we = 1'b0;
      end
    endcase
  end

  // command sequencer
  always @(posedge clk_sys) begin
    if (rst) begin
      state_r       <= ST_BOOT0;
      op_r          <= `SDC_OP_GET;
      axis_r        <= 1'b0;
      bank_r        <= `SDC_BANK_CFG;
      num_r         <= 8'h00;
      data_r        <= 32'h00000000;
      mode_r        <= `SDC_MODE_RST;
      pdd_r         <= `SDC_PDD_RST;
      active_rate_r <= `SDC_RATE_RST;
      rsp_valid_r   <= 1'b0;
      rsp_err_r     <= 1'b0;
      rsp_data_r    <= 32'h00000000;
    end else begin
      rsp_valid_r <= 1'b0;
      case (state_r)
        ST_BOOT0: begin
          state_r <= ST_BOOT1;
        end
        ST_BOOT1: begin
          // rate taken only here, never on a later set
          if (nvm_rd <= `SDC_RATE_MAX) begin
            active_rate_r <= nvm_rd[3:0];                    // see R10
          end
          state_r <= ST_BOOT2;
        end
        ST_BOOT2: begin
          // blank or corrupt store leaves reset values
          if (nvm_rd <= {24'h000000, `SDC_MODE_RUN_EN}) begin
            mode_r <= nvm_rd[7:0];                           // see R13
          end
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          if (cmd_valid) begin
            op_r    <= cmd_op;
            axis_r  <= cmd_axis;
            bank_r  <= cmd_bank;
            num_r   <= cmd_num;
            data_r  <= cmd_data;
            state_r <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (need_rd) begin
            state_r <= ST_WAIT;
          end else begin
            state_r     <= ST_IDLE;
            rsp_valid_r <= 1'b1;
            rsp_err_r   <= bad;
            rsp_data_r  <= 32'h00000000;                     // see R12
            if (!bad && a_mode) begin
              if (op_get) begin
                rsp_data_r <= mode_w;
              end
              if (op_set) begin
                if (data_r <= {24'h000000, `SDC_MODE_RUN_EN}) begin
                  mode_r <= data_r[7:0];
                end else begin
                  rsp_err_r <= 1'b1;                         // see R13
                end
              end
            end
            if (!bad && a_pdd) begin
              if (op_get) begin
                rsp_data_r <= pdd_w;
              end
              if (op_set) begin
                if (data_r[31:16] == 16'h0000 && data_r[15:0] != 16'h0000) begin
                  pdd_r <= data_r[15:0];
                end else begin
                  rsp_err_r <= 1'b1;
                end
              end
            end
          end
        end
        ST_WAIT: begin
          state_r     <= ST_IDLE;
          rsp_valid_r <= 1'b1;
          rsp_err_r   <= 1'b0;
          rsp_data_r  <= 32'h00000000;
          if (g_auto && op_get) begin
            rsp_data_r <= nvm_rd;                            // see R11
          end
          if (g_user && op_get) begin
            rsp_data_r <= ram_rd;
          end
          if (a_mode) begin
            if (nvm_rd <= {24'h000000, `SDC_MODE_RUN_EN}) begin
              mode_r <= nvm_rd[7:0];
            end else begin
              rsp_err_r <= 1'b1;                             // see R13
            end
          end
          if (a_pdd) begin
            if (nvm_rd[31:16] == 16'h0000 && nvm_rd[15:0] != 16'h0000) begin
              pdd_r <= nvm_rd[15:0];
            end else begin
              rsp_err_r <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // bank 0 auto range and bank 2 store slots, see R7 R8
  sdc_param_mem #(
    .AW (8),
    .DW (32)
  ) u_nvm (
    .clk_sys (clk_sys),
    .we      (nvm_we),
    .addr    (nvm_addr),
    .wdata   (nvm_wd),
    .rdata   (nvm_rd)
  );

  // working user and interrupt variables
  sdc_param_mem #(
    .AW (7),
    .DW (32)
  ) u_ram (
    .clk_sys (clk_sys),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wd),
    .rdata   (ram_rd)
  );

  // step/dir current control
  reg              step_d_r;
  reg              auto_run_r;
  reg [TICK_W-1:0] tick_r;
  reg [15:0]       idle_r;
  wire             step_edge = step_in && !step_d_r;
  wire             auto_mode = (mode_r == `SDC_MODE_AUTO) ||
                               (mode_r == `SDC_MODE_AUTO_EN);

  // hold-delay timer runs in 10 ms ticks from the last step
  always @(posedge clk_sys) begin
    if (rst) begin
      step_d_r   <= 1'b0;
      auto_run_r <= 1'b0;
      tick_r     <= {TICK_W{1'b0}};
      idle_r     <= 16'h0000;
    end else begin
      step_d_r <= step_in;
      if (!auto_mode) begin
        auto_run_r <= 1'b0;
        tick_r     <= {TICK_W{1'b0}};
        idle_r     <= 16'h0000;
      end else if (step_edge) begin
        auto_run_r <= 1'b1;                                  // see R3
        tick_r     <= {TICK_W{1'b0}};
        idle_r     <= 16'h0000;
      end else if (auto_run_r) begin
        if (tick_r == TICK_CYC[TICK_W-1:0] - 1'b1) begin
          tick_r <= {TICK_W{1'b0}};
          if (idle_r + 16'h0001 >= pdd_r) begin
            auto_run_r <= 1'b0;                              // see R3
            idle_r     <= 16'h0000;
          end else begin
            idle_r <= idle_r + 16'h0001;
          end
        end else begin
          tick_r <= tick_r + 1'b1;
        end
      end
    end
  end

  // current and driver stage selection
  always @(posedge clk_sys) begin
    if (rst) begin
      run_current_r  <= 1'b0;
      driver_on_r    <= 1'b1;
      step_mode_on_r <= 1'b0;
    end else begin
      step_mode_on_r <= (mode_r != `SDC_MODE_NORMAL);
      driver_on_r    <= 1'b1;
      case (mode_r)
        `SDC_MODE_NORMAL: begin
          run_current_r <= motion_run_req;                   // see R1
        end
        `SDC_MODE_ENSEL: begin
          run_current_r <= enable_in;                        // see R2
        end
        `SDC_MODE_AUTO: begin
          run_current_r <= auto_run_r || step_edge;          // see R3
        end
        `SDC_MODE_RUN: begin
          run_current_r <= 1'b1;                             // see R4
        end
        `SDC_MODE_AUTO_EN: begin
          run_current_r <= auto_run_r || step_edge;          // see R5
          driver_on_r   <= enable_in;                        // see R5
        end
        `SDC_MODE_RUN_EN: begin
          run_current_r <= 1'b1;                             // see R6
          driver_on_r   <= enable_in;                        // see R6
        end
        default: begin
          run_current_r <= motion_run_req;
        end
      endcase
    end
  end
endmodule // sdc_top

/* verif/sdc_props.sv */
// Purpose: port-level checks of the step/dir current block
// Assumes: bound to sdc_top, one clock, rst synchronous
// Notes:   up_r hides the boot window after each reset
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_props #(
  parameter TICK_CYC = 4
) (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // command and answer
  input wire        cmd_valid,
  input wire        cmd_ready,
  input wire [2:0]  cmd_op,
  input wire        cmd_axis,
  input wire [1:0]  cmd_bank,
  input wire [7:0]  cmd_num,
  input wire [31:0] cmd_data,
  input wire        rsp_valid_r,
  input wire        rsp_err_r,
  input wire [31:0] rsp_data_r,
  // motor side
  input wire        step_in,
  input wire        enable_in,
  input wire        motion_run_req,
  input wire        run_current_r,
  input wire        driver_on_r,
  input wire        step_mode_on_r,
  input wire [3:0]  active_rate_r
);
  wire      take;
  reg [2:0] up_r;
  assign take = cmd_valid && cmd_ready;
  always @(posedge clk_sys) begin
    if (rst) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ans; take |-> ##[2:3] rsp_valid_r; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  // ready returns together with a one-cycle answer, stays low on an op that waits for read data
  property p_busy; take |=> !cmd_ready ##1 (cmd_ready == rsp_valid_r); endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_b1;
    take && !cmd_axis && cmd_bank == `SDC_BANK_UNUSED && cmd_op == `SDC_OP_GET
    |-> ##[2:3] rsp_valid_r && rsp_data_r == 32'h0 && !rsp_err_r;
  endproperty
  a_b1: assert property (p_b1) else $error("unused bank read");
  property p_b0lo;
    take && !cmd_axis && cmd_bank == `SDC_BANK_CFG && cmd_num < `SDC_AUTO_LO
    |-> ##[2:3] rsp_valid_r && rsp_err_r;
  endproperty
  a_b0lo: assert property (p_b0lo) else $error("low bank0 accepted");
  property p_b3st;
    take && !cmd_axis && cmd_bank == `SDC_BANK_IRQ && cmd_op == `SDC_OP_STORE
    |-> ##[2:3] rsp_valid_r && rsp_err_r;
  endproperty
  a_b3st: assert property (p_b3st) else $error("bank3 store accepted");
  property p_mbad;
    take && cmd_axis && cmd_num == `SDC_AX_MODE && cmd_op == `SDC_OP_SET && cmd_data > 32'h5
    |-> ##[2:3] rsp_valid_r && rsp_err_r;
  endproperty
  a_mbad: assert property (p_mbad) else $error("bad mode accepted");
  property p_rate; up_r == 3'h7 |-> $stable(active_rate_r); endproperty
  a_rate: assert property (p_rate) else $error("rate moved");
  property p_m0;
    up_r == 3'h7 && !step_mode_on_r && !$past(step_mode_on_r) && !$past(step_mode_on_r, 2)
    |-> run_current_r == $past(motion_run_req);
  endproperty
  a_m0: assert property (p_m0) else $error("mode 0 current");
  c_step: cover property (step_mode_on_r && $rose(run_current_r));
  c_off: cover property ($fell(driver_on_r));
  c_err: cover property (rsp_valid_r && rsp_err_r);
endmodule // sdc_props
bind sdc_top sdc_props #(.TICK_CYC(TICK_CYC)) sdc_props_inst (
  .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_axis(cmd_axis), .cmd_bank(cmd_bank), .cmd_num(cmd_num),
  .cmd_data(cmd_data), .rsp_valid_r(rsp_valid_r), .rsp_err_r(rsp_err_r),
  .rsp_data_r(rsp_data_r), .step_in(step_in), .enable_in(enable_in),
  .motion_run_req(motion_run_req), .run_current_r(run_current_r),
  .driver_on_r(driver_on_r), .step_mode_on_r(step_mode_on_r),
  .active_rate_r(active_rate_r));

/* verif/sdc_src_model.sv */
// Purpose: step pulse and enable source on the connector
// Assumes: driven by the bench through its tasks
// Notes:   enable idles high, step idles low
`timescale 1ns/1ps
module sdc_src_model (
  // clock
  input wire clk_sys,
  // connector
  output reg step_in,
  output reg enable_in
);
  initial begin
    step_in = 1'b0;
    enable_in = 1'b1;
  end
  // slow source waits before its edge
  task pulse(input integer slow);
    begin
      repeat (slow) @(posedge clk_sys);
      @(posedge clk_sys);
      step_in <= 1'b1;
      @(posedge clk_sys);
      step_in <= 1'b0;
    end
  endtask
  // level picks current or gates drivers
  task set_en(input reg lvl);
    begin
      @(posedge clk_sys);
      enable_in <= lvl;
    end
  endtask
endmodule // sdc_src_model

/* verif/sdc_top_bench.sv */
// Purpose: self-checking bench for sdc_top
// Assumes: short tick so hold delays stay a few cycles
// Notes:   reset doubles as power cycle for rate checks
`timescale 1ns/1ps
`include "sdc_regs.vh"
module sdc_top_bench;
  reg         clk_sys, rst, cmd_valid, cmd_axis, motion_run_req;
  reg  [2:0]  cmd_op;
  reg  [1:0]  cmd_bank;
  reg  [7:0]  cmd_num;
  reg  [31:0] cmd_data;
  wire        cmd_ready, rsp_valid_r, rsp_err_r, step_in, enable_in;
  wire        run_current_r, driver_on_r, step_mode_on_r;
  wire [31:0] rsp_data_r;
  wire [3:0]  active_rate_r;
  integer     err_total, samples_checked, cyc;
  sdc_top #(.TICK_CYC(4)) sdc_top_inst (.clk_sys(clk_sys), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_axis(cmd_axis),
    .cmd_bank(cmd_bank), .cmd_num(cmd_num), .cmd_data(cmd_data),
    .rsp_valid_r(rsp_valid_r), .rsp_err_r(rsp_err_r), .rsp_data_r(rsp_data_r),
    .step_in(step_in), .enable_in(enable_in), .motion_run_req(motion_run_req),
    .run_current_r(run_current_r), .driver_on_r(driver_on_r),
    .step_mode_on_r(step_mode_on_r), .active_rate_r(active_rate_r));
  sdc_src_model sdc_src_model_inst (.clk_sys(clk_sys), .step_in(step_in),
    .enable_in(enable_in));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task give_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // cut a hang short; whole run is a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task tk(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task cmd(input [2:0] op, input ax, input [1:0] bk, input [7:0] num,
           input [31:0] d, input e, input [31:0] xd, input ck);
    integer n;
    begin
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_axis <= ax;
      cmd_bank <= bk;
      cmd_num <= num;
      cmd_data <= d;
      n = 0;
      @(posedge clk_sys);
      while (cmd_ready !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      cmd_valid <= 1'b0;
      n = 0;
      @(posedge clk_sys);
      while (rsp_valid_r !== 1'b1 && n < 6) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      chk(rsp_valid_r, 1);
      chk(rsp_err_r, e);
      if (ck) chk(rsp_data_r, xd);
    end
  endtask
  task mode(input [7:0] m);
    cmd(`SDC_OP_SET, 1, 0, `SDC_AX_MODE, {24'h0, m}, 0, 0, 0);
  endtask
  task do_reset;
    begin
      @(posedge clk_sys);
      rst <= 1'b1;
      tk(5);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk(run_current_r, 0);
      chk(driver_on_r, 1);
      chk(step_mode_on_r, 0);
      tk(6);
    end
  endtask
  task t_modes;
    begin
      @(posedge clk_sys);
      motion_run_req <= 1'b1;
      tk(3);
      chk(run_current_r, 1);
      sdc_src_model_inst.pulse(0);
      motion_run_req <= 1'b0;
      tk(3);
      chk(run_current_r, 0);
      mode(1);
      tk(1);
      chk(step_mode_on_r, 1);
      sdc_src_model_inst.set_en(1);
      tk(3);
      chk(run_current_r, 1);
      sdc_src_model_inst.set_en(0);
      tk(3);
      chk(run_current_r, 0);
      chk(driver_on_r, 1);
      cmd(`SDC_OP_SET, 1, 0, `SDC_AX_PDD, 2, 0, 0, 0);
      mode(2);
      sdc_src_model_inst.pulse(3);
      tk(2);
      chk({driver_on_r, run_current_r}, 3);
      // run holds 2 * 4 cycles after the step edge, then one more to launch hold
      tk(7);
      chk(run_current_r, 1);
      tk(1);
      chk(run_current_r, 0);
      mode(4);
      sdc_src_model_inst.set_en(1);
      sdc_src_model_inst.pulse(0);
      tk(2);
      chk({driver_on_r, run_current_r}, 3);
      sdc_src_model_inst.set_en(0);
      tk(3);
      chk(driver_on_r, 0);
      tk(12);
      chk(run_current_r, 0);
      mode(3);
      tk(20);
      chk({driver_on_r, run_current_r}, 3);
      mode(5);
      tk(3);
      chk({driver_on_r, run_current_r}, 1);
      sdc_src_model_inst.set_en(1);
      tk(3);
      chk({driver_on_r, run_current_r}, 3);
      cmd(`SDC_OP_SET, 1, 0, `SDC_AX_MODE, 6, 1, 0, 0);
      cmd(`SDC_OP_GET, 1, 0, `SDC_AX_MODE, 0, 0, 5, 1);
      mode(0);
      $display("test modes done");
    end
  endtask
  task t_params;
    begin
      cmd(`SDC_OP_SET, 0, 0, `SDC_RATE_NUM, 3, 0, 0, 0);
      chk(active_rate_r, 0);
      cmd(`SDC_OP_GET, 0, 0, `SDC_RATE_NUM, 0, 0, 3, 1);
      cmd(`SDC_OP_GET, 0, 0, 8'h0a, 0, 1, 0, 0);
      cmd(`SDC_OP_SET, 0, 1, 8'h05, 7, 0, 0, 0);
      cmd(`SDC_OP_GET, 0, 1, 8'h05, 0, 0, 0, 1);
      cmd(`SDC_OP_SET, 0, 2, 8'h05, 10, 0, 0, 0);
      cmd(`SDC_OP_ADD, 0, 2, 8'h05, 5, 0, 0, 0);
      cmd(`SDC_OP_STORE, 0, 2, 8'h05, 0, 0, 0, 0);
      cmd(`SDC_OP_SET, 0, 2, 8'h05, 0, 0, 0, 0);
      cmd(`SDC_OP_RESTORE, 0, 2, 8'h05, 0, 0, 0, 0);
      cmd(`SDC_OP_GET, 0, 2, 8'h05, 0, 0, 15, 1);
      cmd(`SDC_OP_STORE, 0, 3, 8'h01, 0, 1, 0, 0);
      cmd(`SDC_OP_ADD, 1, 0, `SDC_AX_PDD, 1, 1, 0, 0);
      cmd(3'h7, 0, 0, `SDC_RATE_NUM, 0, 1, 0, 0);
      cmd(`SDC_OP_STORE, 1, 0, `SDC_AX_PDD, 0, 0, 0, 0);
      cmd(`SDC_OP_SET, 1, 0, `SDC_AX_PDD, 7, 0, 0, 0);
      cmd(`SDC_OP_RESTORE, 1, 0, `SDC_AX_PDD, 0, 0, 0, 0);
      cmd(`SDC_OP_GET, 1, 0, `SDC_AX_PDD, 0, 0, 2, 1);
      do_reset;
      chk(active_rate_r, 3);
      cmd(`SDC_OP_GET, 0, 0, `SDC_RATE_NUM, 0, 0, 3, 1);
      $display("test params done");
    end
  endtask
  initial begin
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    motion_run_req = 1'b0;
    do_reset;
    chk(active_rate_r, 0);
    cmd(`SDC_OP_GET, 1, 0, `SDC_AX_MODE, 0, 0, 0, 1);
    $display("test reset done");
    t_modes;
    t_params;
    give_verdict;
  end
endmodule // sdc_top_bench
